// ==== rtl/tbtc_map.svh ====
/*
 Offsets, field positions, reset values and response codes of the
 timer control block. Assumes inclusion by bare name from rtl/.
*/
`ifndef TBTC_MAP_SVH
`define TBTC_MAP_SVH

// ==========================================================
// register offsets (byte addresses)
`define TBTC_OFS_EVEN 8'h00
`define TBTC_OFS_ODD 8'h04
`define TBTC_OFS_STAT 8'h08

// ==========================================================
// timer_control field positions
`define TBTC_BIT_ON 15
`define TBTC_BIT_STOP_IN_IDLE 13
`define TBTC_BIT_GATE 7
`define TBTC_PS_HI 6
`define TBTC_PS_LO 4
`define TBTC_BIT_PAIR 3
`define TBTC_BIT_SRC 1

// ==========================================================
// status field positions
`define TBTC_ST_RUN_LO 0
`define TBTC_ST_RUN_HI 1
`define TBTC_ST_PAIR 2

// ==========================================================
// reset values and implemented-bit masks
`define TBTC_CTRL_RESET 16'h0000
`define TBTC_MASK_EVEN 16'hA0FA
`define TBTC_MASK_ODD 16'hA0F2

// ==========================================================
// prescale terminal counts (divisor minus one)
`define TBTC_PS_TC1 8'h00
`define TBTC_PS_TC2 8'h01
`define TBTC_PS_TC4 8'h03
`define TBTC_PS_TC8 8'h07
`define TBTC_PS_TC16 8'h0F
`define TBTC_PS_TC32 8'h1F
`define TBTC_PS_TC64 8'h3F
`define TBTC_PS_TC256 8'hFF

// ==========================================================
// bus responses
`define TBTC_RESP_OKAY 2'h0
`define TBTC_RESP_SLVERR 2'h2

`endif

// ==== rtl/tbtc_pkg.sv ====
/*
 Types and shared helpers of the timer control block.
 Assumes tbtc_map.svh is on the include path.
*/
`include "tbtc_map.svh"

package tbtc_pkg;

    typedef enum logic {TBTC_WR_COLLECT, TBTC_WR_RESP} tbtc_wr_state_t;
    typedef enum logic {TBTC_RD_IDLE, TBTC_RD_VALID} tbtc_rd_state_t;

    // divisor minus one for each prescale code
    function automatic logic [7:0] tbtc_ps_limit(input logic [2:0] sel);
        case (sel)
            3'h0: tbtc_ps_limit = `TBTC_PS_TC1;
            3'h1: tbtc_ps_limit = `TBTC_PS_TC2;
            3'h2: tbtc_ps_limit = `TBTC_PS_TC4;
            3'h3: tbtc_ps_limit = `TBTC_PS_TC8;
            3'h4: tbtc_ps_limit = `TBTC_PS_TC16;
            3'h5: tbtc_ps_limit = `TBTC_PS_TC32;
            3'h6: tbtc_ps_limit = `TBTC_PS_TC64;
            default: tbtc_ps_limit = `TBTC_PS_TC256;
        endcase
    endfunction

    // gate bit reads zero while the external source is selected
    function automatic logic [31:0] tbtc_readback(input logic [15:0] ctrl);
        logic [15:0] v;
        v = ctrl;
        if (ctrl[`TBTC_BIT_SRC]) begin
            v[`TBTC_BIT_GATE] = 1'b0;
        end
        tbtc_readback = {16'h0000, v};
    endfunction

    // byte-lane write limited to implemented bits
    function automatic logic [15:0] tbtc_merge(input logic [15:0] old,
        input logic [31:0] data, input logic [3:0] strb, input logic [15:0] mask);
        logic [15:0] v;
        v = old;
        if (strb[0]) begin
            v[7:0] = data[7:0];
        end
        if (strb[1]) begin
            v[15:8] = data[15:8];
        end
        tbtc_merge = v & mask;
    endfunction

endpackage

// ==== rtl/tbtc_tick_src.sv ====
/*
 Count-source selector for one timer: internal bus clock, optionally
 gated, or rising edges of the external clock input.
 Assumes ext_clk and gate_in are synchronous to clk.
*/
`timescale 1ns/10ps
`default_nettype none

module tbtc_tick_src
    import tbtc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic src_sel,
    input wire logic gate_en,
    input wire logic ext_clk,
    input wire logic gate_in,
    output logic tick
);

    logic ext_prev;
    logic next_ext_prev;

    always_comb begin
        next_ext_prev = ext_clk;
        if (src_sel) begin
            tick = ext_clk & ~ext_prev; // [RULE12]
        end else if (gate_en) begin
            tick = gate_in; // [RULE4]
        end else begin
            tick = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_prev <= 1'b0;
        end else begin
            ext_prev <= next_ext_prev;
        end
    end

endmodule

`default_nettype wire

// ==== rtl/tbtc_prescaler.sv ====
/*
 Input prescaler for one timer: passes one tick in every 1..256.
 Assumes tick_in is a one-cycle enable in the clk domain.
*/
`timescale 1ns/10ps
`default_nettype none

module tbtc_prescaler
    import tbtc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [2:0] sel,
    input wire logic tick_in,
    output logic tick_out
);

    logic [7:0] count;
    logic [7:0] next_count;
    logic next_tick_out;

    always_comb begin
        next_count = count;
        next_tick_out = 1'b0;
        // cleared while stopped so a restart begins a full period
        if (!run) begin
            next_count = 8'h00;
        end else if (tick_in) begin
            if (count >= tbtc_ps_limit(sel)) begin // [RULE5]
                next_count = 8'h00;
                next_tick_out = 1'b1;
            end else begin
                next_count = count + 8'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= 8'h00;
            tick_out <= 1'b0;
        end else begin
            count <= next_count;
            tick_out <= next_tick_out;
        end
    end

endmodule

`default_nettype wire

// ==== rtl/tbtc_top.sv ====
/*
 Control logic of an even/odd pair of 16-bit timers: two control
 registers and a status register behind an AXI4-Lite slave, source
 select, gating, prescaling, idle stop and 32-bit pairing.
 Assumes all inputs synchronous to clk; the count datapath consumes
 tick_lo, tick_hi and pair_mode.
*/
// Our own choices: the AXI4-Lite interface to the registers and the placing of the registers.
// Contract
// [RULE1] A timer counts only while its enable bit is set.
// [RULE2] With stop-in-idle set the timer halts in idle, otherwise it keeps running.
// [RULE3] With the external source selected the gate bit is ignored and reads zero.
// [RULE4] With the internal source, the gate bit turns gated accumulation on or off.
// [RULE5] The prescale field divides by 1, 2, 4, 8, 16, 32, 64 or 256.
// [RULE6] The pairing bit exists only on the even timer.
// [RULE7] In pair mode the odd timer's enable, gate, prescale and source bits are ignored.
// [RULE8] Software clears the odd stop-in-idle bit for a pair to run in idle.
// [RULE9] Software avoids register access in the cycle after clearing enable at 1:1.
// [RULE10] Unimplemented control bits read as zero.
// [RULE11] Pairing cascades the even timer (low half) with the odd one.
// [RULE12] Source select picks the external clock when set, the bus clock when clear.
`timescale 1ns/10ps
`default_nettype none

module tbtc_top
    import tbtc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic idle_mode,
    input wire logic ext_clk_lo,
    input wire logic ext_clk_hi,
    input wire logic gate_lo,
    input wire logic gate_hi,
    output logic tick_lo,
    output logic tick_hi,
    output logic pair_mode
);

    // ==========================================================
    // write channel and control registers
    tbtc_wr_state_t wr_state, next_wr_state;
    logic aw_got, next_aw_got, w_got, next_w_got;
    logic [7:0] wr_addr, next_wr_addr;
    logic [31:0] wr_data, next_wr_data;
    logic [3:0] wr_strb, next_wr_strb;
    logic next_awready, next_wready, next_bvalid;
    logic [1:0] next_bresp;
    logic [15:0] ctrl_even, next_ctrl_even, ctrl_odd, next_ctrl_odd;
    logic aw_hs, w_hs;

    assign aw_hs = s_axi_awvalid & s_axi_awready;
    assign w_hs = s_axi_wvalid & s_axi_wready;

    always_comb begin
        next_wr_state = wr_state;
        next_aw_got = aw_got | aw_hs;
        next_w_got = w_got | w_hs;
        next_wr_addr = aw_hs ? s_axi_awaddr : wr_addr;
        next_wr_data = w_hs ? s_axi_wdata : wr_data;
        next_wr_strb = w_hs ? s_axi_wstrb : wr_strb;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_ctrl_even = ctrl_even;
        next_ctrl_odd = ctrl_odd;
        case (wr_state)
            TBTC_WR_COLLECT: begin
                if (next_aw_got && next_w_got) begin
                    next_bvalid = 1'b1;
                    next_bresp = `TBTC_RESP_OKAY;
                    next_aw_got = 1'b0;
                    next_w_got = 1'b0;
                    next_wr_state = TBTC_WR_RESP;
                    if (next_wr_addr == `TBTC_OFS_EVEN) begin
                        next_ctrl_even = tbtc_merge(ctrl_even, next_wr_data,
                            next_wr_strb, `TBTC_MASK_EVEN); // [RULE10]
                    end else if (next_wr_addr == `TBTC_OFS_ODD) begin
                        // odd timer has no pairing bit
                        next_ctrl_odd = tbtc_merge(ctrl_odd, next_wr_data,
                            next_wr_strb, `TBTC_MASK_ODD); // [RULE6]
                    end else if (next_wr_addr != `TBTC_OFS_STAT) begin
                        next_bresp = `TBTC_RESP_SLVERR;
                    end
                end
            end
            TBTC_WR_RESP: begin
                if (s_axi_bready) begin
                    next_bvalid = 1'b0;
                    next_wr_state = TBTC_WR_COLLECT;
                end
            end
            default: begin
                next_wr_state = TBTC_WR_COLLECT;
            end
        endcase
        next_awready = (next_wr_state == TBTC_WR_COLLECT) && !next_aw_got;
        next_wready = (next_wr_state == TBTC_WR_COLLECT) && !next_w_got;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_state <= TBTC_WR_COLLECT;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 32'h00000000;
            wr_strb <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `TBTC_RESP_OKAY;
            ctrl_even <= `TBTC_CTRL_RESET;
            ctrl_odd <= `TBTC_CTRL_RESET;
        end else begin
            wr_state <= next_wr_state;
            aw_got <= next_aw_got;
            w_got <= next_w_got;
            wr_addr <= next_wr_addr;
            wr_data <= next_wr_data;
            wr_strb <= next_wr_strb;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            ctrl_even <= next_ctrl_even;
            ctrl_odd <= next_ctrl_odd;
        end
    end

    // ==========================================================
    // effective settings and count path
    logic paired, run_lo, run_hi, idle_stop_lo, idle_stop_hi;
    logic src_hi, gate_en_hi, src_tick_lo, src_tick_hi;
    logic [2:0] ps_hi;

    assign paired = ctrl_even[`TBTC_BIT_PAIR];
    // a pair stops in idle if either half asks for it
    assign idle_stop_lo = idle_mode & (ctrl_even[`TBTC_BIT_STOP_IN_IDLE]
        | (paired & ctrl_odd[`TBTC_BIT_STOP_IN_IDLE])); // [RULE2] [RULE8]
    assign idle_stop_hi = idle_mode & ctrl_odd[`TBTC_BIT_STOP_IN_IDLE]; // [RULE2]
    assign run_lo = ctrl_even[`TBTC_BIT_ON] & ~idle_stop_lo; // [RULE1]
    // high half advances on the low half's carry in the datapath
    assign run_hi = ~paired & ctrl_odd[`TBTC_BIT_ON] & ~idle_stop_hi; // [RULE1] [RULE7]
    assign src_hi = ctrl_odd[`TBTC_BIT_SRC];
    assign gate_en_hi = ctrl_odd[`TBTC_BIT_GATE];
    assign ps_hi = ctrl_odd[`TBTC_PS_HI:`TBTC_PS_LO];

    tbtc_tick_src u_src_lo (
        .clk(clk),
        .rst_n(rst_n),
        .src_sel(ctrl_even[`TBTC_BIT_SRC]),
        .gate_en(ctrl_even[`TBTC_BIT_GATE]),
        .ext_clk(ext_clk_lo),
        .gate_in(gate_lo),
        .tick(src_tick_lo)
    );

    tbtc_tick_src u_src_hi (
        .clk(clk),
        .rst_n(rst_n),
        .src_sel(src_hi),
        .gate_en(gate_en_hi),
        .ext_clk(ext_clk_hi),
        .gate_in(gate_hi),
        .tick(src_tick_hi)
    );

    tbtc_prescaler u_ps_lo (
        .clk(clk),
        .rst_n(rst_n),
        .run(run_lo),
        .sel(ctrl_even[`TBTC_PS_HI:`TBTC_PS_LO]),
        .tick_in(src_tick_lo),
        .tick_out(tick_lo)
    );

    tbtc_prescaler u_ps_hi (
        .clk(clk),
        .rst_n(rst_n),
        .run(run_hi),
        .sel(ps_hi),
        .tick_in(src_tick_hi),
        .tick_out(tick_hi)
    );

    // ==========================================================
    // status and pairing output
    logic [2:0] status, next_status;
    logic next_pair_mode;

    always_comb begin
        next_status = 3'h0;
        next_status[`TBTC_ST_RUN_LO] = run_lo;
        next_status[`TBTC_ST_RUN_HI] = run_hi;
        next_status[`TBTC_ST_PAIR] = paired;
        next_pair_mode = paired; // [RULE11]
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status <= 3'h0;
            pair_mode <= 1'b0;
        end else begin
            status <= next_status;
            pair_mode <= next_pair_mode;
        end
    end

    // ==========================================================
    // read channel
    tbtc_rd_state_t rd_state, next_rd_state;
    logic [31:0] next_rdata, rd_even, rd_odd;
    logic [1:0] next_rresp;
    logic next_rvalid, next_arready;

    assign rd_even = tbtc_readback(ctrl_even); // [RULE3]
    assign rd_odd = tbtc_readback(ctrl_odd); // [RULE3]

    always_comb begin
        next_rd_state = rd_state;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        next_rvalid = s_axi_rvalid;
        case (rd_state)
            TBTC_RD_IDLE: begin
                if (s_axi_arvalid) begin
                    next_rd_state = TBTC_RD_VALID;
                    next_rvalid = 1'b1;
                    next_rresp = `TBTC_RESP_OKAY;
                    if (s_axi_araddr == `TBTC_OFS_EVEN) begin
                        next_rdata = rd_even;
                    end else if (s_axi_araddr == `TBTC_OFS_ODD) begin
                        next_rdata = rd_odd;
                    end else if (s_axi_araddr == `TBTC_OFS_STAT) begin
                        next_rdata = {29'h00000000, status};
                    end else begin
                        next_rdata = 32'h00000000;
                        next_rresp = `TBTC_RESP_SLVERR;
                    end
                end
            end
            TBTC_RD_VALID: begin
                if (s_axi_rready) begin
                    next_rvalid = 1'b0;
                    next_rd_state = TBTC_RD_IDLE;
                end
            end
            default: begin
                next_rd_state = TBTC_RD_IDLE;
            end
        endcase
        next_arready = (next_rd_state == TBTC_RD_IDLE);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_state <= TBTC_RD_IDLE;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `TBTC_RESP_OKAY;
        end else begin
            rd_state <= next_rd_state;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_div2_steady;
        (run_lo && src_tick_lo && ctrl_even[`TBTC_PS_HI:`TBTC_PS_LO] == 3'h1) [*2];
    endsequence

    a_off_no_tick: assert property (!run_lo |=> !tick_lo) // [RULE1]
        else $error("low tick while stopped");
    a_idle_halts: assert property (idle_mode && ctrl_even[`TBTC_BIT_STOP_IN_IDLE] |=> !tick_lo) // [RULE2]
        else $error("low tick in idle with stop-in-idle set");
    a_div1_runs: assert property (run_lo && src_tick_lo
        && ctrl_even[`TBTC_PS_HI:`TBTC_PS_LO] == 3'h0 |=> tick_lo) // [RULE5]
        else $error("undivided tick missing");
    a_gate_reads_zero: assert property (ctrl_even[`TBTC_BIT_SRC]
        |-> !rd_even[`TBTC_BIT_GATE]) // [RULE3]
        else $error("gate bit visible with external source");
    a_gate_blocks: assert property (!ctrl_even[`TBTC_BIT_SRC]
        && ctrl_even[`TBTC_BIT_GATE] && !gate_lo |=> !tick_lo) // [RULE4]
        else $error("tick passed closed gate");
    a_div2_period: assert property (tick_lo ##0 s_div2_steady |-> !tick_lo ##1 tick_lo) // [RULE5]
        else $error("divide-by-two period wrong");
    a_odd_no_pair: assert property (rd_odd[`TBTC_BIT_PAIR] == 1'b0) // [RULE6]
        else $error("odd pairing bit present");
    a_pair_hi_quiet: assert property (paired |=> !tick_hi) // [RULE7]
        else $error("odd tick in pair mode");
    a_pair_follows: assert property ($rose(paired) |=> pair_mode) // [RULE11]
        else $error("pair mode not raised");
    a_unimpl_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000
        && !s_axi_rdata[14] && s_axi_rdata[12:8] == 5'h00) // [RULE10]
        else $error("unimplemented bits read nonzero");
    a_ext_no_edge: assert property (ctrl_even[`TBTC_BIT_SRC] && !ext_clk_lo
        |=> !tick_lo) // [RULE12]
        else $error("tick without external edge");

endmodule

`default_nettype wire

// ==== test/type_b_timer_control_tb.sv ====
/*
 Self-checking bench of the timer control block: control and status
 registers over AXI4-Lite, tick counts on the count-enable outputs.
 Assumes the rtl/ header and package are compiled before this file.
*/
`timescale 1ns/10ps
`default_nettype none
`include "tbtc_map.svh"

module type_b_timer_control_tb;

    // ==========================================================
    // signals
    logic clk;
    logic rst_n;
    logic [7:0] awaddr;
    logic awvalid;
    logic awready;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready;
    logic idle_mode;
    logic gate_lo;
    logic gate_hi;
    logic tick_lo;
    logic tick_hi;
    logic pair_mode;
    logic [2:0] ext_cnt = 3'h0;
    int fails;
    int num_checks;
    int div_tab [8] = '{1, 2, 4, 8, 16, 32, 64, 256};

    tbtc_top DUT (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .idle_mode(idle_mode), .ext_clk_lo(ext_cnt[2]), .ext_clk_hi(ext_cnt[2]),
        .gate_lo(gate_lo), .gate_hi(gate_hi), .tick_lo(tick_lo), .tick_hi(tick_hi),
        .pair_mode(pair_mode));

    // ==========================================================
    // clock and external count clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // one rising edge every 8 bus cycles
    always @(posedge clk) begin
        ext_cnt <= ext_cnt + 3'h1;
    end

    // ==========================================================
    // checking and closing
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic hang();
        fails++;
        $display("ERROR at %0t: watchdog timeout", $time);
    endtask

    task automatic conclude();
        $display("checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ==========================================================
    // bus tasks
    // waits for the answer however long; only the watchdog ends a hang
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready) begin
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
            end
        end while (bvalid !== 1'b1);
        check({30'h0, bresp}, {30'h0, er});
        bready <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
            end
        end while (rvalid !== 1'b1);
        check(rdata, exp);
        check({30'h0, rresp}, {30'h0, er});
        rready <= 1'b0;
    endtask

    task automatic set_ctrl(input logic [31:0] e, input logic [31:0] o);
        axi_write(`TBTC_OFS_EVEN, e, `TBTC_RESP_OKAY);
        axi_write(`TBTC_OFS_ODD, o, `TBTC_RESP_OKAY);
    endtask

    // settle long enough for the slowest divisor, then a window of 512
    task automatic run_check(input int exp_lo, input int exp_hi);
        int lo = 0;
        int hi = 0;
        repeat (260) @(posedge clk);
        repeat (512) begin
            @(posedge clk);
            if (tick_lo === 1'b1) begin
                lo++;
            end
            if (tick_hi === 1'b1) begin
                hi++;
            end
        end
        check(lo, exp_lo);
        check(hi, exp_hi);
    endtask

    // ==========================================================
    // watchdog
    initial begin
        #400000;
        hang();
        conclude();
    end

    // ==========================================================
    // tests
    initial begin
        rst_n = 1'b0;
        awaddr = 8'h00;
        awvalid = 1'b0;
        wdata = 32'h0;
        wstrb = 4'h0;
        wvalid = 1'b0;
        bready = 1'b0;
        araddr = 8'h00;
        arvalid = 1'b0;
        rready = 1'b0;
        idle_mode = 1'b0;
        gate_lo = 1'b0;
        gate_hi = 1'b0;
        fails = 0;
        num_checks = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(`TBTC_OFS_EVEN, 32'h0, `TBTC_RESP_OKAY);
        rd_chk(`TBTC_OFS_ODD, 32'h0, `TBTC_RESP_OKAY);
        rd_chk(`TBTC_OFS_STAT, 32'h0, `TBTC_RESP_OKAY);
        run_check(0, 0);
        axi_write(`TBTC_OFS_EVEN, 32'hFFFFFFFF, `TBTC_RESP_OKAY);
        rd_chk(`TBTC_OFS_EVEN, 32'h0000A07A, `TBTC_RESP_OKAY);
        axi_write(`TBTC_OFS_ODD, 32'hFFFFFFFF, `TBTC_RESP_OKAY);
        rd_chk(`TBTC_OFS_ODD, 32'h0000A072, `TBTC_RESP_OKAY);
        axi_write(`TBTC_OFS_EVEN, 32'h0000FFFD, `TBTC_RESP_OKAY);
        rd_chk(`TBTC_OFS_EVEN, 32'h0000A0F8, `TBTC_RESP_OKAY);
        set_ctrl(32'h0, 32'h00000008);
        // spacing after clearing enable before the next access
        repeat (2) @(posedge clk);
        rd_chk(`TBTC_OFS_ODD, 32'h0, `TBTC_RESP_OKAY);
        axi_write(8'h0C, 32'h0000FFFF, `TBTC_RESP_SLVERR);
        rd_chk(8'h0C, 32'h0, `TBTC_RESP_SLVERR);
        axi_write(`TBTC_OFS_STAT, 32'h0000FFFF, `TBTC_RESP_OKAY);
        rd_chk(`TBTC_OFS_STAT, 32'h0, `TBTC_RESP_OKAY);
        for (int i = 0; i < 8; i++) begin
            set_ctrl(32'h00008000 | (32'(i) << 4), 32'h0);
            run_check(512 / div_tab[i], 0);
        end
        set_ctrl(32'h0, 32'h00008010);
        run_check(0, 256);
        rd_chk(`TBTC_OFS_STAT, 32'h00000002, `TBTC_RESP_OKAY);
        idle_mode <= 1'b1;
        set_ctrl(32'h0000A000, 32'h0);
        run_check(0, 0);
        set_ctrl(32'h00008000, 32'h0);
        run_check(512, 0);
        idle_mode <= 1'b0;
        set_ctrl(32'h00008080, 32'h0);
        run_check(0, 0);
        gate_lo <= 1'b1;
        run_check(512, 0);
        gate_lo <= 1'b0;
        // gate bit set but ignored with the external source
        set_ctrl(32'h00008082, 32'h00008002);
        run_check(64, 64);
        set_ctrl(32'h00008012, 32'h0);
        run_check(32, 0);
        // odd settings would stop or divide the pair if honoured
        set_ctrl(32'h00008008, 32'h00000072);
        run_check(512, 0);
        check({31'h0, pair_mode}, 32'h1);
        rd_chk(`TBTC_OFS_STAT, 32'h00000005, `TBTC_RESP_OKAY);
        idle_mode <= 1'b1;
        set_ctrl(32'h00008008, 32'h00002000);
        run_check(0, 0);
        set_ctrl(32'h00008008, 32'h0);
        run_check(512, 0);
        idle_mode <= 1'b0;
        set_ctrl(32'h0, 32'h0);
        repeat (4) @(posedge clk);
        check({31'h0, pair_mode}, 32'h0);
        conclude();
    end

endmodule
`default_nettype wire
